// [tcp_chk.sv]
// assertion checker on the timer block ports
`timescale 1ns/1ps
`include "tcp_defines.svh"
module tcp_chk (
	// clock, reset and read port
	input wire logic               i_ref_clk,
	input wire logic               i_rst_n,
	input wire logic               i_rd,
	input wire logic [`TCP_DW-1:0] o_rdata,
	// routed signals
	input wire logic               i_tmr_reset,
	input wire logic               i_kill,
	input wire logic               o_cmp,
	input wire logic               o_cmp_n,
	input wire logic               o_tc,
	input wire tcp_pkg::tcp_evt_s  o_events
);
	import tcp_pkg::*;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_tc_pulse; o_events.tc |=> !o_events.tc; endproperty
	a_tc_pulse: assert property (p_tc_pulse) else $error("tc pulse too long");
	property p_cap_pulse; o_events.cap |=> !o_events.cap; endproperty
	a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse too long");
	property p_cmp_pulse; o_events.cmp |=> !o_events.cmp; endproperty
	a_cmp_pulse: assert property (p_cmp_pulse) else $error("compare pulse too long");
	property p_kill; i_kill |=> !o_cmp && !o_cmp_n; endproperty
	a_kill: assert property (p_kill) else $error("pwm active under kill");
	property p_pair; !(o_cmp && o_cmp_n); endproperty
	a_pair: assert property (p_pair) else $error("both pwm outputs high");
	property p_gap;
		($rose(o_cmp) || $rose(o_cmp_n)) |-> !$past(o_cmp) && !$past(o_cmp_n);
	endproperty
	a_gap: assert property (p_gap) else $error("no deadband gap");
	property p_tcsel; o_tc |-> o_events.tc || o_cmp_n; endproperty
	a_tcsel: assert property (p_tcsel) else $error("tc output from no source");
	property p_rst_load; i_tmr_reset [*2] |=> !o_events.tc; endproperty
	a_rst_load: assert property (p_rst_load) else $error("tc while reloading");
	property p_rdata; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : tcp_chk

bind tcp_timer tcp_chk tcp_chk_i (.i_ref_clk, .i_rst_n, .i_rd, .o_rdata, .i_tmr_reset,
	.i_kill, .o_cmp, .o_cmp_n, .o_tc, .o_events);

// [tcp_clk_sel.sv]
// counting clock source selection as a one-cycle tick
`timescale 1ns/1ps
module tcp_clk_sel #(
	parameter int N_SRC = 4
) (
	// clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	// sources and selection
	input  wire logic [N_SRC-1:0]         i_src,
	input  wire logic [$clog2(N_SRC)-1:0] i_sel,
	// tick out
	output logic                          o_tick
);

	// parameter check
	if (N_SRC < 2 || (N_SRC & (N_SRC - 1)) != 0) begin : g_bad_n_src
		$error("N_SRC must be a power of two, at least 2");
	end

	logic [N_SRC-1:0] prev_ff;
	logic [N_SRC-1:0] rise;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= i_src;
		end
	end

	// rising edge of each source
	for (genvar g = 0; g < N_SRC; g++) begin : g_rise
		assign rise[g] = i_src[g] & ~prev_ff[g];
	end

	assign o_tick = rise[i_sel];

endmodule : tcp_clk_sel

// [tcp_deadband.sv]
// complementary output pair with deadband and kill
`timescale 1ns/1ps
module tcp_deadband #(
	parameter int DB_W = 8
) (
	// clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	// control
	input  wire logic            i_pwm,
	input  wire logic            i_kill,
	input  wire logic [DB_W-1:0] i_db,
	// outputs
	output logic                 o_pos,
	output logic                 o_neg
);

	// parameter check
	if (DB_W < 1) begin : g_bad_db_w
		$error("DB_W must be at least 1");
	end

	logic            lvl_ff;
	logic [DB_W-1:0] dcnt_ff;
	logic            pos_ff;
	logic            neg_ff;
	logic            idle;

	assign idle = (i_pwm == lvl_ff) && (dcnt_ff == '0);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lvl_ff  <= 1'b0;
			dcnt_ff <= '0;
		end else begin
			lvl_ff <= i_pwm;
			if (i_pwm != lvl_ff) begin
				dcnt_ff <= i_db;
			end else if (dcnt_ff != '0) begin
				dcnt_ff <= dcnt_ff - 1'b1;
			end
		end
	end

	// both low during the gap and while killed
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos_ff <= 1'b0;
			neg_ff <= 1'b0;
		end else begin
			pos_ff <= ~i_kill & idle & lvl_ff;
			neg_ff <= ~i_kill & idle & ~lvl_ff;
		end
	end

	assign o_pos = pos_ff;
	assign o_neg = neg_ff;

endmodule : tcp_deadband

// [tcp_defines.svh]
// register map, field positions, reset values and widths of the timer block
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

`define TCP_AW            4
`define TCP_DW            16

`define TCP_ADDR_CTRL     4'h0
`define TCP_ADDR_PERIOD   4'h1
`define TCP_ADDR_COMPARE  4'h2
`define TCP_ADDR_COUNT    4'h3
`define TCP_ADDR_CAPTURE  4'h4
`define TCP_ADDR_DEADBAND 4'h5
`define TCP_ADDR_IRQ_STAT 4'h6
`define TCP_ADDR_IRQ_CLR  4'h7
`define TCP_ADDR_IRQ_EN   4'h8

`define TCP_CTRL_EN       0
`define TCP_CTRL_START    1
`define TCP_CTRL_MODE     3:2
`define TCP_CTRL_CMP      6:4
`define TCP_CTRL_CLK      8:7
`define TCP_CTRL_TCSEL    9

`define TCP_IRQ_TC        0
`define TCP_IRQ_CMP       1
`define TCP_IRQ_CAP       2
`define TCP_IRQ_W         3

`define TCP_RST_PERIOD    16'hffff
`define TCP_RST_COMPARE   16'h8000
`define TCP_RST_DEADBAND  16'h0000
`define TCP_RST_IRQ       3'h0
`define TCP_ZERO_DATA     16'h0000

`endif

// [tcp_far.sv]
// routed logic model feeding the timer fabric inputs
`timescale 1ns/1ps
module tcp_far (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// bench requests: kill, capture, reset, enable
	input  wire logic [3:0] i_req,
	// routed signals
	output logic [3:0]      o_src,
	output logic [3:0]      o_ctl
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_src <= 4'h0;
			o_ctl <= 4'h0;
		end else begin
			o_src <= o_src + 4'h1;
			o_ctl <= i_req;
		end
	end
endmodule : tcp_far

// [tcp_pkg.sv]
// types shared by the timer block
package tcp_pkg;

	typedef enum logic [1:0] {
		TCP_MODE_FREE    = 2'b00,
		TCP_MODE_ONESHOT = 2'b01,
		TCP_MODE_ENCTL   = 2'b10
	} tcp_mode_e;

	typedef enum logic [2:0] {
		TCP_CMP_LT  = 3'b000,
		TCP_CMP_LTE = 3'b001,
		TCP_CMP_EQ  = 3'b010,
		TCP_CMP_GTE = 3'b011,
		TCP_CMP_GT  = 3'b100
	} tcp_cmp_e;

	typedef struct packed {
		logic      tc_sel;
		logic [1:0] clk_sel;
		tcp_cmp_e  cmp_mode;
		tcp_mode_e mode;
		logic      enable;
	} tcp_ctrl_s;

	typedef struct packed {
		logic cap;
		logic cmp;
		logic tc;
	} tcp_evt_s;

endpackage : tcp_pkg

// [tcp_timer.sv]
// 16-bit down-counting timer, counter and pwm unit with register port
//
// How it works
// - the counter is sixteen bits wide and only ever counts down
// - compare asserts on less, less-equal, equal, greater-equal or greater
// - period reloads on start, on the reset input and on terminal count
// - terminal count, compare true and capture each may raise the interrupt
// - one-shot runs a single period then stops until started again
// - enable-controlled mode decrements only while the enable input is high
// - free-running mode reloads after terminal count and keeps counting
// - compare output, terminal count or complementary compare, interrupt line
// - kill forces the compare-driven outputs inactive; routed logic drives kill
// - a capture event latches the full counter value for software to read
// - true and complementary pwm with programmable deadband, both off in gap
// - counting clock chosen from several sources by configuration
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tcp_defines.svh"
module tcp_timer #(
	parameter int CNT_W = 16,
	parameter int DB_W  = 8,
	parameter int N_CLK = 4
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	// register port
	input  wire logic [`TCP_AW-1:0] i_addr,
	input  wire logic [`TCP_DW-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [`TCP_DW-1:0]     o_rdata,
	// routed inputs
	input  wire logic [N_CLK-1:0]  i_clk_src,
	input  wire logic              i_enable,
	input  wire logic              i_tmr_reset,
	input  wire logic              i_capture,
	input  wire logic              i_kill,
	// routed outputs
	output logic                   o_cmp,
	output logic                   o_cmp_n,
	output logic                   o_tc,
	output logic                   o_irq,
	output tcp_pkg::tcp_evt_s      o_events
);
	import tcp_pkg::*;

	// parameter check
	if (CNT_W < 2 || CNT_W > `TCP_DW) begin : g_bad_cnt_w
		$error("CNT_W must lie between 2 and the data width");
	end
	if (DB_W < 1 || DB_W > `TCP_DW) begin : g_bad_db_w
		$error("DB_W must lie between 1 and the data width");
	end
	if (N_CLK != 2 && N_CLK != 4) begin : g_bad_n_clk
		$error("N_CLK must be 2 or 4");
	end

	localparam int SEL_W = $clog2(N_CLK);

	// reset release
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// register state
	tcp_ctrl_s             ctrl_ff;
	logic [CNT_W-1:0]      period_ff;
	logic [CNT_W-1:0]      compare_ff;
	logic [DB_W-1:0]       db_ff;
	logic [`TCP_IRQ_W-1:0] irq_stat_ff;
	logic [`TCP_IRQ_W-1:0] irq_en_ff;
	logic [`TCP_DW-1:0]    rdata_ff;

	// counter state
	logic [CNT_W-1:0]      count_ff;
	logic [CNT_W-1:0]      capture_ff;
	logic                  run_ff;
	logic                  tc_ff;
	logic                  cmp_ff;
	logic                  cap_prev_ff;
	tcp_evt_s              evt_ff;

	// decode
	logic                  wr_ctrl;
	logic                  start;
	logic                  reload;
	logic                  tick;
	logic                  step;
	logic                  at_zero;
	logic                  tc_evt;
	logic                  cmp_now;
	logic                  cmp_evt;
	logic                  cap_evt;
	logic [`TCP_IRQ_W-1:0] irq_set;
	logic [`TCP_IRQ_W-1:0] irq_clr;
	logic                  pwm_pos;
	logic                  pwm_neg;
	logic [`TCP_DW-1:0]    nxt_rdata;

	assign wr_ctrl = i_wr && (i_addr == `TCP_ADDR_CTRL);
	assign start   = wr_ctrl && i_wdata[`TCP_CTRL_START];
	assign reload  = start || i_tmr_reset;
	assign at_zero = (count_ff == '0);

	// counting clock source
	tcp_clk_sel #(
		.N_SRC (N_CLK)
	) u_clk_sel (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_n_ff),
		.i_src   (i_clk_src),
		.i_sel   (ctrl_ff.clk_sel[SEL_W-1:0]),
		.o_tick  (tick)
	);

	// count only when running, and gated by enable in its mode
	always_comb begin
		step = run_ff && tick;
		if (ctrl_ff.mode == TCP_MODE_ENCTL) begin
			step = step && i_enable;
		end
	end

	assign tc_evt = step && at_zero && !reload;

	// control register
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_ff <= '0;
		end else if (wr_ctrl) begin
			ctrl_ff.enable   <= i_wdata[`TCP_CTRL_EN];
			ctrl_ff.mode     <= tcp_mode_e'(i_wdata[`TCP_CTRL_MODE]);
			ctrl_ff.cmp_mode <= tcp_cmp_e'(i_wdata[`TCP_CTRL_CMP]);
			ctrl_ff.clk_sel  <= i_wdata[`TCP_CTRL_CLK];
			ctrl_ff.tc_sel   <= i_wdata[`TCP_CTRL_TCSEL];
		end
	end

	// period, compare and deadband registers
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			period_ff  <= CNT_W'(`TCP_RST_PERIOD);
			compare_ff <= CNT_W'(`TCP_RST_COMPARE);
			db_ff      <= DB_W'(`TCP_RST_DEADBAND);
		end else if (i_wr) begin
			unique case (i_addr)
				`TCP_ADDR_PERIOD:   period_ff  <= i_wdata[CNT_W-1:0];
				`TCP_ADDR_COMPARE:  compare_ff <= i_wdata[CNT_W-1:0];
				`TCP_ADDR_DEADBAND: db_ff      <= i_wdata[DB_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// run state
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			run_ff <= 1'b0;
		end else if (start) begin
			run_ff <= i_wdata[`TCP_CTRL_EN];
		end else if (!ctrl_ff.enable) begin
			run_ff <= 1'b0;
		end else if (tc_evt && ctrl_ff.mode == TCP_MODE_ONESHOT) begin
			run_ff <= 1'b0;
		end
	end

	// down counter
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			count_ff <= CNT_W'(`TCP_RST_PERIOD);
		end else if (reload) begin
			count_ff <= period_ff;
		end else if (step) begin
			if (at_zero) begin
				count_ff <= period_ff;
			end else begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

	// terminal count pulse
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tc_ff <= 1'b0;
		end else begin
			tc_ff <= tc_evt;
		end
	end

	// comparator
	always_comb begin
		unique case (ctrl_ff.cmp_mode)
			TCP_CMP_LT:  cmp_now = count_ff <  compare_ff;
			TCP_CMP_LTE: cmp_now = count_ff <= compare_ff;
			TCP_CMP_EQ:  cmp_now = count_ff == compare_ff;
			TCP_CMP_GTE: cmp_now = count_ff >= compare_ff;
			TCP_CMP_GT:  cmp_now = count_ff >  compare_ff;
			default:     cmp_now = 1'b0;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cmp_ff <= 1'b0;
		end else begin
			cmp_ff <= cmp_now;
		end
	end

	assign cmp_evt = cmp_now && !cmp_ff;

	// pwm pair with deadband and kill
	tcp_deadband #(
		.DB_W (DB_W)
	) u_deadband (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_n_ff),
		.i_pwm   (cmp_ff),
		.i_kill  (i_kill),
		.i_db    (db_ff),
		.o_pos   (pwm_pos),
		.o_neg   (pwm_neg)
	);

	// capture
	assign cap_evt = i_capture && !cap_prev_ff;

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cap_prev_ff <= 1'b0;
		end else begin
			cap_prev_ff <= i_capture;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			capture_ff <= '0;
		end else if (cap_evt) begin
			capture_ff <= count_ff;
		end
	end

	// event pulses
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			evt_ff <= '0;
		end else begin
			evt_ff.tc  <= tc_evt;
			evt_ff.cmp <= cmp_evt;
			evt_ff.cap <= cap_evt;
		end
	end

	// interrupt status, set wins over clear
	always_comb begin
		irq_set               = '0;
		irq_set[`TCP_IRQ_TC]  = tc_evt;
		irq_set[`TCP_IRQ_CMP] = cmp_evt;
		irq_set[`TCP_IRQ_CAP] = cap_evt;
		irq_clr               = '0;
		if (i_wr && i_addr == `TCP_ADDR_IRQ_CLR) begin
			irq_clr = i_wdata[`TCP_IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			irq_stat_ff <= `TCP_RST_IRQ;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			irq_en_ff <= `TCP_RST_IRQ;
		end else if (i_wr && i_addr == `TCP_ADDR_IRQ_EN) begin
			irq_en_ff <= i_wdata[`TCP_IRQ_W-1:0];
		end
	end

	// read path
	always_comb begin
		nxt_rdata = `TCP_ZERO_DATA;
		unique case (i_addr)
			`TCP_ADDR_CTRL: begin
				nxt_rdata[`TCP_CTRL_EN]    = ctrl_ff.enable;
				nxt_rdata[`TCP_CTRL_START] = run_ff;
				nxt_rdata[`TCP_CTRL_MODE]  = ctrl_ff.mode;
				nxt_rdata[`TCP_CTRL_CMP]   = ctrl_ff.cmp_mode;
				nxt_rdata[`TCP_CTRL_CLK]   = ctrl_ff.clk_sel;
				nxt_rdata[`TCP_CTRL_TCSEL] = ctrl_ff.tc_sel;
			end
			`TCP_ADDR_PERIOD:   nxt_rdata = `TCP_DW'(period_ff);
			`TCP_ADDR_COMPARE:  nxt_rdata = `TCP_DW'(compare_ff);
			`TCP_ADDR_COUNT:    nxt_rdata = `TCP_DW'(count_ff);
			`TCP_ADDR_CAPTURE:  nxt_rdata = `TCP_DW'(capture_ff);
			`TCP_ADDR_DEADBAND: nxt_rdata = `TCP_DW'(db_ff);
			`TCP_ADDR_IRQ_STAT: nxt_rdata = `TCP_DW'(irq_stat_ff);
			`TCP_ADDR_IRQ_EN:   nxt_rdata = `TCP_DW'(irq_en_ff);
			default:            nxt_rdata = `TCP_ZERO_DATA;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdata_ff <= `TCP_ZERO_DATA;
		end else if (i_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= `TCP_ZERO_DATA;
		end
	end

	// outputs
	assign o_rdata  = rdata_ff;
	assign o_cmp    = pwm_pos;
	assign o_cmp_n  = pwm_neg;
	assign o_tc     = ctrl_ff.tc_sel ? pwm_neg : tc_ff;
	assign o_irq    = |(irq_stat_ff & irq_en_ff);
	assign o_events = evt_ff;

endmodule : tcp_timer

// [timer_counter_pwm_16bit_tb.sv]
// self-checking bench for the timer block
`timescale 1ns/1ps
`include "tcp_defines.svh"
module timer_counter_pwm_16bit_tb;
	import tcp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_d = 1'b0;
	logic [3:0]  req = 4'h0;
	logic [3:0]  src;
	logic [3:0]  ctl;
	logic [15:0] rdata;
	logic        cmp;
	logic        cmp_n;
	logic        tc;
	logic        irq;
	tcp_evt_s    ev;
	logic [15:0] exp_q[$];
	int          n_fail = 0;
	int          total_checks = 0;
	int          seed = 1;
	int          n, p, c, db;
	integer      hi, lo, ot;
	always #20 clk = ~clk;
	tcp_timer tcp_timer_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_clk_src(src),
		.i_enable(ctl[0]), .i_tmr_reset(ctl[1]), .i_capture(ctl[2]), .i_kill(ctl[3]),
		.o_cmp(cmp), .o_cmp_n(cmp_n), .o_tc(tc), .o_irq(irq), .o_events(ev));
	tcp_far tcp_far_i (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_src(src), .o_ctl(ctl));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp=%h got=%h", nm, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	always @(posedge clk) begin
		if (rd_d) chk("rdata", rdata, exp_q.pop_front());
		rd_d <= rd;
	end
	task automatic wait_tc(output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (ev.tc !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			n_fail++;
			wrap_up();
		end
	endtask : wait_tc
	task automatic count(input int len);
		hi = 0;
		lo = 0;
		ot = 0;
		repeat (len) begin
			@(negedge clk);
			hi += cmp;
			lo += cmp_n;
			ot += tc;
		end
	endtask : count
	function automatic logic [15:0] ctrl(input logic [1:0] md, input logic [2:0] cm,
		input logic [1:0] ck, input logic ts);
		return {6'h00, ts, ck, cm, md, 2'b11};
	endfunction : ctrl
	function automatic int hit(input int m, input int v, input int c);
		case (m)
			0: return v < c;
			1: return v <= c;
			2: return v == c;
			3: return v >= c;
			default: return v > c;
		endcase
	endfunction : hit
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 16; a++) begin
			rd_reg(a[3:0], (a == 1 || a == 3) ? `TCP_RST_PERIOD :
				(a == 2) ? `TCP_RST_COMPARE : `TCP_ZERO_DATA);
		end
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			p = 1 + ($random(seed) & 3);
			wr_reg(`TCP_ADDR_PERIOD, 16'(p));
			wr_reg(`TCP_ADDR_CTRL, ctrl(2'b00, 3'h0, k[1:0], 1'b0));
			repeat (2) wait_tc(n);
			wait_tc(n);
			chk("interval", 16'(n), 16'((p + 1) << (k + 1)));
		end
		$display("test period done");
		wr_reg(`TCP_ADDR_PERIOD, 16'h0007);
		for (int m = 0; m < 5; m++) begin
			c = 2 + ($unsigned($random(seed)) % 4);
			db = m & 1;
			wr_reg(`TCP_ADDR_COMPARE, 16'(c));
			wr_reg(`TCP_ADDR_DEADBAND, 16'(db));
			wr_reg(`TCP_ADDR_CTRL, ctrl(2'b00, m[2:0], 2'b00, 1'b1));
			repeat (3) wait_tc(n);
			count(16);
			n = 0;
			for (int v = 0; v < 8; v++) n += hit(m, v, c);
			chk("cmp", 16'(hi), 16'(2 * n - 1 - db));
			chk("cmp_n", 16'(lo), 16'(15 - 2 * n - db));
			chk("tc_sel", 16'(ot), 16'(15 - 2 * n - db));
		end
		@(posedge clk) req[3] <= 1'b1;
		repeat (3) @(posedge clk);
		count(8);
		chk("kill", 16'(hi + lo + ot), 16'h0000);
		req[3] <= 1'b0;
		$display("test compare done");
		wr_reg(`TCP_ADDR_PERIOD, 16'h0003);
		wr_reg(`TCP_ADDR_CTRL, ctrl(2'b01, 3'h0, 2'b00, 1'b0));
		repeat (2) @(negedge clk);
		wait_tc(n);
		count(40);
		chk("oneshot", 16'(ot), 16'h0000);
		rd_reg(`TCP_ADDR_CTRL, 16'h0005);
		rd_reg(`TCP_ADDR_COUNT, 16'h0003);
		rd_reg(`TCP_ADDR_IRQ_STAT, 16'h0003);
		$display("test oneshot done");
		wr_reg(`TCP_ADDR_CTRL, ctrl(2'b10, 3'h0, 2'b00, 1'b0));
		count(40);
		chk("held", 16'(ot), 16'h0000);
		rd_reg(`TCP_ADDR_COUNT, 16'h0003);
		@(posedge clk) req[0] <= 1'b1;
		repeat (2) wait_tc(n);
		chk("gated", 16'(n), 16'h0008);
		@(posedge clk) req[0] <= 1'b0;
		$display("test enable done");
		p = $random(seed);
		wr_reg(`TCP_ADDR_PERIOD, 16'(p));
		wr_reg(`TCP_ADDR_CTRL, 16'h0002);
		repeat (4) @(posedge clk);
		wr_reg(`TCP_ADDR_IRQ_CLR, 16'h0007);
		@(posedge clk) req[2] <= 1'b1;
		repeat (3) @(posedge clk);
		req[2] <= 1'b0;
		rd_reg(`TCP_ADDR_CAPTURE, 16'(p));
		rd_reg(`TCP_ADDR_IRQ_STAT, 16'h0004);
		@(negedge clk) chk("masked", 16'(irq), 16'h0000);
		wr_reg(`TCP_ADDR_IRQ_EN, 16'h0004);
		repeat (2) @(negedge clk);
		chk("irq", 16'(irq), 16'h0001);
		wr_reg(`TCP_ADDR_IRQ_CLR, 16'h0004);
		repeat (2) @(negedge clk);
		chk("cleared", 16'(irq), 16'h0000);
		$display("test capture done");
		wr_reg(`TCP_ADDR_CTRL, 16'h0003);
		repeat (20) @(posedge clk);
		req[1] <= 1'b1;
		repeat (3) @(posedge clk);
		wr_reg(`TCP_ADDR_CTRL, 16'h0000);
		req[1] <= 1'b0;
		rd_reg(`TCP_ADDR_COUNT, 16'(p));
		repeat (3) @(posedge clk);
		$display("test reload done");
		wrap_up();
	end
endmodule : timer_counter_pwm_16bit_tb
